// ---- timer_consts.vh ----
// constants for the reader protocol timer unit
// What this block does
// - transmit end starts the no-response timer
// - step is 64 or 4096 carrier periods
// - normal mode timeout: flag and close gate
// - normal mode reply start stops timer quietly
// - unconditional mode flags unless an active mode peer field stops it, ignores clear
// - unconditional timeout closes gate unless receiving
// - start command starts or restarts timer
// - active mode ignores start command
// - active mode timeout before peer field flags
// - general timer trigger: reception start or end
// - active mode: general timer times field off
// - general timer flags on every expiry
// - general start command starts or restarts
// - wake start command refused in wake mode
// - wake command starts oscillator and timer
// - wake expiry sets wake flag, interrupt
// - wake timer runs without carrier clock
// - clear stops timers except wake, unconditional
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH
`define STEP_FINE_DIV    13'h0040
`define STEP_COARSE_DIV  13'h1000
`define DIV_W            13
`define NRT_W            16
`define GPT_W            16
`define WUT_W            16
`define GPT_TRIG_SOR     1'b0
`define GPT_TRIG_EOR     1'b1
`endif

// ---- step_divider.v ----
// enable-pulse divider producing no-response timer steps
`timescale 1ns/1ps
module step_divider (
    input  wire        clock_i,
    input  wire        rst_n,
    input  wire        carrier_tick_i,
    input  wire        restart_i,
    input  wire        coarse_i,
    output reg         step_o
);
`include "timer_consts.vh"
    reg  [`DIV_W-1:0] count;
    wire [`DIV_W-1:0] limit;
    // step of 64 or 4096 carrier periods
    assign limit = coarse_i ? `STEP_COARSE_DIV : `STEP_FINE_DIV;
    // restart keeps the first step a full one
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            count  <= 13'h0000;
            step_o <= 1'b0;
        end else if (restart_i) begin
            count  <= 13'h0000;
            step_o <= 1'b0;
        end else if (carrier_tick_i) begin
            if (count == limit - 13'h0001) begin
                count  <= 13'h0000;
                step_o <= 1'b1;
            end else begin
                count  <= count + 13'h0001;
                step_o <= 1'b0;
            end
        end else begin
            step_o <= 1'b0;
        end
    end
endmodule

// ---- down_counter.v ----
// loadable down counter with one-cycle expiry pulse
`timescale 1ns/1ps
module down_counter #(
    parameter W = 16
) (
    input  wire         clock_i,
    input  wire         rst_n,
    input  wire         load_i,
    input  wire [W-1:0] value_i,
    input  wire         stop_i,
    input  wire         tick_i,
    output reg          running_o,
    output reg          expire_o
);
    reg [W-1:0] count;
    // load wins over stop so a restart is never lost; zero never runs
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            count     <= {W{1'b0}};
            running_o <= 1'b0;
            expire_o  <= 1'b0;
        end else begin
            expire_o <= 1'b0;
            if (load_i) begin
                count     <= value_i;
                running_o <= (value_i != {W{1'b0}});
            end else if (stop_i) begin
                running_o <= 1'b0;
            end else if (running_o && tick_i) begin
                if (count == {{(W-1){1'b0}}, 1'b1}) begin
                    running_o <= 1'b0;
                    expire_o  <= 1'b1;
                end
                count <= count - {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule

// ---- reader_protocol_timers.v ----
// timer unit: no-response, general-purpose and wake-up timers
`timescale 1ns/1ps
module reader_protocol_timers (
    input  wire        clock_i,
    input  wire        rst_n_i,
    input  wire        carrier_tick_i,
    input  wire        rc_tick_i,
    input  wire        tx_end_i,
    input  wire        reply_start_i,
    input  wire        reply_busy_i,
    input  wire        rx_sof_i,
    input  wire        rx_eof_i,
    input  wire        peer_field_on_i,
    input  wire        field_off_i,
    input  wire        active_mode_i,
    input  wire        wake_mode_i,
    input  wire        cmd_clear_i,
    input  wire        cmd_start_nrt_i,
    input  wire        cmd_start_gpt_i,
    input  wire        cmd_start_wut_i,
    input  wire [7:0]  nrt_setting1_i,
    input  wire [7:0]  nrt_setting2_i,
    input  wire        nrt_step_i,
    input  wire        nrt_uncond_i,
    input  wire        gpt_trigger_i,
    input  wire [15:0] gpt_setting_i,
    input  wire [15:0] wut_setting_i,
    input  wire        nre_flag_clr_i,
    input  wire        gpt_flag_clr_i,
    input  wire        wake_timer_flag_clr_i,
    output reg         nre_flag_o,
    output reg         gpt_flag_o,
    output reg         wake_timer_flag_o,
    output reg         rx_gate_close_o,
    output reg         rc_osc_en_o,
    output wire        nrt_running_o,
    output wire        gpt_running_o,
    output wire        wut_running_o
);
`include "timer_consts.vh"

    // ****************************************************
    // reset release
    // ****************************************************
    reg rst_s1;
    reg rst_n;
    // async assert, sync release
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    // ****************************************************
    // external event synchronisers
    // ****************************************************
    // events from the analog front end and rc domain pass three flops;
    // a change counts when stages two and three agree
    localparam NS = 9;
    wire [NS-1:0] raw_in;
    reg  [NS-1:0] sa;
    reg  [NS-1:0] sb;
    reg  [NS-1:0] sc;
    reg  [NS-1:0] lvl;
    reg  [NS-1:0] rise;
    assign raw_in = {rc_tick_i, carrier_tick_i, tx_end_i, reply_start_i,
                     reply_busy_i, rx_sof_i, rx_eof_i, peer_field_on_i,
                     field_off_i};
    genvar g;
    generate
        for (g = 0; g < NS; g = g + 1) begin : sync_bit
            // filtered level plus rising-edge pulse per input
            always @(posedge clock_i or negedge rst_n) begin
                if (!rst_n) begin
                    sa[g]   <= 1'b0;
                    sb[g]   <= 1'b0;
                    sc[g]   <= 1'b0;
                    lvl[g]  <= 1'b0;
                    rise[g] <= 1'b0;
                end else begin
                    sa[g]   <= raw_in[g];
                    sb[g]   <= sa[g];
                    sc[g]   <= sb[g];
                    rise[g] <= 1'b0;
                    if (sb[g] == sc[g] && sc[g] != lvl[g]) begin
                        lvl[g]  <= sc[g];
                        rise[g] <= sc[g];
                    end
                end
            end
        end
    endgenerate
    wire rc_tick     = rise[8];
    wire car_tick    = rise[7];
    wire tx_end      = rise[6];
    wire reply_start = rise[5];
    wire reply_busy  = lvl[4];
    wire rx_sof      = rise[3];
    wire rx_eof      = rise[2];
    wire peer_on     = rise[1];
    wire field_off   = rise[0];

    // ****************************************************
    // no-response timer
    // ****************************************************
    wire [15:0] nrt_value;
    wire        nrt_step;
    wire        nrt_expire;
    wire        nrt_load;
    wire        nrt_stop;
    wire        nrt_cmd_ok;
    reg         nrt_reply_seen;
    // two setting bytes form the count, setting 1 as high byte
    assign nrt_value = {nrt_setting1_i, nrt_setting2_i};
    // direct start refused in active mode
    assign nrt_cmd_ok = cmd_start_nrt_i & ~active_mode_i;
    // transmit end or direct command (re)start
    assign nrt_load = tx_end | nrt_cmd_ok;
    // reply start stops it in normal mode; clear unless unconditional
    assign nrt_stop = (reply_start & ~nrt_uncond_i & ~active_mode_i)
                    | (peer_on & active_mode_i)
                    | (cmd_clear_i & ~nrt_uncond_i);

    step_divider u_nrt_div (
        .clock_i        (clock_i),
        .rst_n          (rst_n),
        .carrier_tick_i (car_tick),
        .restart_i      (nrt_load),
        .coarse_i       (nrt_step_i),
        .step_o         (nrt_step)
    );

    down_counter #(.W(`NRT_W)) u_nrt (
        .clock_i   (clock_i),
        .rst_n     (rst_n),
        .load_i    (nrt_load),
        .value_i   (nrt_value),
        .stop_i    (nrt_stop),
        .tick_i    (nrt_step),
        .running_o (nrt_running_o),
        .expire_o  (nrt_expire)
    );

    // reply-in-progress memory for unconditional timeout
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            nrt_reply_seen <= 1'b0;
        end else if (nrt_load) begin
            nrt_reply_seen <= 1'b0;
        end else if (reply_start) begin
            nrt_reply_seen <= 1'b1;
        end
    end

    // ****************************************************
    // general-purpose timer
    // ****************************************************
    wire gpt_trig;
    wire gpt_load;
    wire gpt_expire;
    // reception start or end trigger; field off in active mode
    assign gpt_trig = active_mode_i ? field_off :
                      (gpt_trigger_i == `GPT_TRIG_EOR) ? rx_eof
                                                       : rx_sof;
    assign gpt_load = gpt_trig | cmd_start_gpt_i;

    down_counter #(.W(`GPT_W)) u_gpt (
        .clock_i   (clock_i),
        .rst_n     (rst_n),
        .load_i    (gpt_load),
        .value_i   (gpt_setting_i),
        .stop_i    (cmd_clear_i),
        .tick_i    (car_tick),
        .running_o (gpt_running_o),
        .expire_o  (gpt_expire)
    );

    // ****************************************************
    // wake-up timer
    // ****************************************************
    wire wut_load;
    wire wut_expire;
    // refused in wake mode; clear does not stop it
    assign wut_load = cmd_start_wut_i & ~wake_mode_i;

    // rc ticks only: runs with the carrier stopped
    down_counter #(.W(`WUT_W)) u_wut (
        .clock_i   (clock_i),
        .rst_n     (rst_n),
        .load_i    (wut_load),
        .value_i   (wut_setting_i),
        .stop_i    (1'b0),
        .tick_i    (rc_tick),
        .running_o (wut_running_o),
        .expire_o  (wut_expire)
    );

    // rc oscillator enabled while the wake timer runs or is loading
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            rc_osc_en_o <= 1'b0;
        end else begin
            rc_osc_en_o <= (wut_load & (wut_setting_i != 16'h0000))
                         | (wut_running_o & ~wut_expire);
        end
    end

    // ****************************************************
    // flags and receive gate
    // ****************************************************
    // hardware set beats software clear in the same cycle
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            nre_flag_o        <= 1'b0;
            gpt_flag_o        <= 1'b0;
            wake_timer_flag_o <= 1'b0;
            rx_gate_close_o   <= 1'b0;
        end else begin
            // expiry always flags; stop on reply prevents it
            if (nrt_expire) begin
                nre_flag_o <= 1'b1;
            end else if (nre_flag_clr_i) begin
                nre_flag_o <= 1'b0;
            end
            if (gpt_expire) begin
                gpt_flag_o <= 1'b1;
            end else if (gpt_flag_clr_i) begin
                gpt_flag_o <= 1'b0;
            end
            if (wut_expire) begin
                wake_timer_flag_o <= 1'b1;
            end else if (wake_timer_flag_clr_i) begin
                wake_timer_flag_o <= 1'b0;
            end
            // one-cycle gate-close pulse; spared in unconditional mode if reply underway
            rx_gate_close_o <= nrt_expire &
                               ~(nrt_uncond_i & (reply_busy |
                                                 nrt_reply_seen));
        end
    end
endmodule

// ---- tick_src.sv ----
// carrier and rc oscillator tick source at the far side of the timers
`timescale 1ns/1ps
module tick_src (
    input  wire logic clock_i,
    input  wire logic rc_en_i,
    output logic      carrier_tick_o,
    output logic      rc_tick_o
);
    logic [3:0] cnt = 4'h0;
    // carrier period of 8 clocks stays well below the clock/4 limit
    always @(posedge clock_i) begin
        cnt <= cnt + 4'h1;
        carrier_tick_o <= cnt[2];
        rc_tick_o <= rc_en_i & cnt[3]; // rc clock idles low when off
    end
endmodule

// ---- rpt_chk.sv ----
// assertions on the ports of the reader protocol timer unit
`timescale 1ns/1ps
module rpt_chk (
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    input wire logic        active_mode_i,
    input wire logic        wake_mode_i,
    input wire logic        cmd_clear_i,
    input wire logic        cmd_start_nrt_i,
    input wire logic        cmd_start_gpt_i,
    input wire logic        cmd_start_wut_i,
    input wire logic [15:0] gpt_setting_i,
    input wire logic [15:0] wut_setting_i,
    input wire logic        gpt_flag_o,
    input wire logic        wake_timer_flag_o,
    input wire logic        rx_gate_close_o,
    input wire logic        rc_osc_en_o,
    input wire logic        nrt_running_o,
    input wire logic        gpt_running_o,
    input wire logic        wut_running_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // the gate strobe must drop after one cycle
    sequence s_gate_pulse;
        rx_gate_close_o ##1 !rx_gate_close_o;
    endsequence
    chk_gate_one_cycle: assert property (
        $rose(rx_gate_close_o) |-> s_gate_pulse) else $error("gate too long");
    chk_nrt_cmd_refused: assert property (
        active_mode_i && cmd_start_nrt_i && !nrt_running_o |=> !nrt_running_o)
        else $error("nrt started in active mode");
    chk_wut_cmd_refused: assert property (
        wake_mode_i && cmd_start_wut_i && !wut_running_o |=> !wut_running_o)
        else $error("wut started in wake mode");
    chk_gpt_cmd_start: assert property (
        cmd_start_gpt_i && gpt_setting_i != 16'h0000 |=> gpt_running_o)
        else $error("gpt not started");
    chk_gpt_clear_stop: assert property (
        cmd_clear_i && !cmd_start_gpt_i |=> !gpt_running_o)
        else $error("gpt survived clear");
    chk_gpt_expiry_flag: assert property (
        $fell(gpt_running_o) && !$past(cmd_clear_i) |=> gpt_flag_o)
        else $error("gpt expiry without flag");
    chk_wut_clear_kept: assert property (
        cmd_clear_i && wut_running_o |=>
        (wut_running_o or ##1 wake_timer_flag_o)) else $error("wut cleared");
    chk_wut_osc_on: assert property (
        cmd_start_wut_i && !wake_mode_i && wut_setting_i != 16'h0000
        |-> ##[1:3] rc_osc_en_o) else $error("rc oscillator not started");
endmodule
bind reader_protocol_timers rpt_chk u_rpt_chk (
    .clock_i, .rst_n_i, .active_mode_i, .wake_mode_i, .cmd_clear_i,
    .cmd_start_nrt_i, .cmd_start_gpt_i, .cmd_start_wut_i, .gpt_setting_i,
    .wut_setting_i, .gpt_flag_o, .wake_timer_flag_o, .rx_gate_close_o,
    .rc_osc_en_o, .nrt_running_o, .gpt_running_o, .wut_running_o
);

// ---- testbench.sv ----
// self-checking bench for the reader protocol timer unit
`timescale 1ns/1ps
module testbench;
    logic clock_i = 0, rst_n_i = 0, carrier_tick_i, rc_tick_i;
    logic tx_end_i = 0, reply_start_i = 0, reply_busy_i = 0, rx_sof_i = 0;
    logic rx_eof_i = 0, peer_field_on_i = 0, field_off_i = 0;
    logic active_mode_i = 0, wake_mode_i = 0, cmd_clear_i = 0;
    logic cmd_start_nrt_i = 0, cmd_start_gpt_i = 0, cmd_start_wut_i = 0;
    logic nrt_step_i = 0, nrt_uncond_i = 0, gpt_trigger_i = 0;
    logic nre_flag_clr_i = 0, gpt_flag_clr_i = 0, wake_timer_flag_clr_i = 0;
    logic [7:0]  nrt_setting1_i = 8'h00, nrt_setting2_i = 8'h00;
    logic [15:0] gpt_setting_i = 16'h0000, wut_setting_i = 16'h0000;
    logic nre_flag_o, gpt_flag_o, wake_timer_flag_o, rx_gate_close_o;
    logic rc_osc_en_o, nrt_running_o, gpt_running_o, wut_running_o;
    int   fail_count = 0, num_checks = 0, cycles = 0, n, gates = 0;
    reader_protocol_timers u_reader_protocol_timers (.clock_i, .rst_n_i,
        .carrier_tick_i, .rc_tick_i, .tx_end_i, .reply_start_i, .reply_busy_i,
        .rx_sof_i, .rx_eof_i, .peer_field_on_i, .field_off_i, .active_mode_i,
        .wake_mode_i, .cmd_clear_i, .cmd_start_nrt_i, .cmd_start_gpt_i,
        .cmd_start_wut_i, .nrt_setting1_i, .nrt_setting2_i, .nrt_step_i,
        .nrt_uncond_i, .gpt_trigger_i, .gpt_setting_i, .wut_setting_i,
        .nre_flag_clr_i, .gpt_flag_clr_i, .wake_timer_flag_clr_i, .nre_flag_o,
        .gpt_flag_o, .wake_timer_flag_o, .rx_gate_close_o, .rc_osc_en_o,
        .nrt_running_o, .gpt_running_o, .wut_running_o);
    tick_src u_tick_src (.clock_i, .rc_en_i(rc_osc_en_o),
        .carrier_tick_o(carrier_tick_i), .rc_tick_o(rc_tick_i));
    initial forever #25 clock_i = ~clock_i;
    // counts gate strobes; the ceiling cuts a hang well past the ~40k needed
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (rx_gate_close_o === 1'b1) gates <= gates + 1;
        if (cycles == 60000) begin
            fail_count++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // all driving happens 1 ns after a rising edge
    task automatic step(input int k);
        repeat (k) @(posedge clock_i);
        #1;
    endtask
    task automatic pulse(ref logic s, input int w);
        s = 1'b1;
        step(w);
        s = 1'b0;
    endtask
    task automatic wait_hi(ref logic s, input int max);
        n = 0;
        while (s !== 1'b1 && n < max) begin
            step(1);
            n++;
        end
    endtask
    // no-response timer: timeout, reply stop, unconditional mode
    // settings only change while the timer concerned is idle
    // tx_end_i stands in for the serviced transmit-end interrupt
    task automatic t_nrt();
        nrt_setting2_i = 8'h02;
        pulse(tx_end_i, 2);
        wait_hi(nre_flag_o, 1200);
        step(2);
        check(n >= 1010 && n <= 1060, 1);
        check(gates, 1);
        pulse(nre_flag_clr_i, 1);
        {nrt_setting1_i, nrt_setting2_i} = 16'h0100;
        pulse(tx_end_i, 2);
        step(20);
        check(nrt_running_o, 1);
        pulse(reply_start_i, 2);
        step(8);
        check({nrt_running_o, nre_flag_o}, 0);
        {nrt_setting1_i, nrt_setting2_i} = 16'h0001;
        nrt_uncond_i = 1'b1;
        reply_busy_i = 1'b1;
        gates = 0;
        pulse(cmd_start_nrt_i, 1);
        step(300);
        pulse(cmd_start_nrt_i, 1);
        pulse(cmd_clear_i, 1);
        wait_hi(nre_flag_o, 700);
        step(2);
        check(n >= 495 && n <= 530, 1);
        check(gates, 0);
        reply_busy_i = 1'b0;
        pulse(nre_flag_clr_i, 1);
        pulse(cmd_start_nrt_i, 1);
        wait_hi(nre_flag_o, 700);
        step(2);
        check(gates, 1);
        nrt_uncond_i = 1'b0;
        pulse(nre_flag_clr_i, 1);
    endtask
    // active mode: command refused, peer field, field off trigger
    task automatic t_active();
        active_mode_i = 1'b1;
        pulse(cmd_start_nrt_i, 1);
        step(3);
        check(nrt_running_o, 0);
        pulse(tx_end_i, 2);
        step(20);
        pulse(peer_field_on_i, 2);
        step(8);
        check({nrt_running_o, nre_flag_o}, 0);
        pulse(tx_end_i, 2);
        wait_hi(nre_flag_o, 700);
        check(nre_flag_o, 1);
        pulse(nre_flag_clr_i, 1);
        gpt_setting_i = 16'h0003;
        pulse(field_off_i, 2);
        wait_hi(gpt_flag_o, 100);
        check(gpt_flag_o, 1);
        pulse(gpt_flag_clr_i, 1);
        active_mode_i = 1'b0;
    endtask
    // general timer: both triggers, restart, clear, zero setting
    task automatic t_gpt();
        gpt_setting_i = 16'h0004;
        for (int t = 0; t < 2; t++) begin
            gpt_trigger_i = t[0];
            if (t == 0) pulse(rx_eof_i, 2);
            else pulse(rx_sof_i, 2);
            step(10);
            check(gpt_running_o, 0);
            if (t == 0) pulse(rx_sof_i, 2);
            else pulse(rx_eof_i, 2);
            wait_hi(gpt_flag_o, 100);
            check(n >= 24 && n <= 50, 1);
            pulse(gpt_flag_clr_i, 1);
        end
        pulse(cmd_start_gpt_i, 1);
        step(20);
        pulse(cmd_start_gpt_i, 1);
        wait_hi(gpt_flag_o, 100);
        check(n >= 24 && n <= 45, 1);
        pulse(gpt_flag_clr_i, 1);
        pulse(cmd_start_gpt_i, 1);
        pulse(cmd_clear_i, 1);
        step(60);
        check({gpt_running_o, gpt_flag_o}, 0);
        gpt_setting_i = 16'h0000;
        pulse(cmd_start_gpt_i, 1);
        step(60);
        check({gpt_running_o, gpt_flag_o}, 0);
    endtask
    // wake timer, then the coarse no-response step
    task automatic t_wut_coarse();
        {wut_setting_i, wake_mode_i} = 17'h00007;
        pulse(cmd_start_wut_i, 1);
        step(3);
        check({wut_running_o, rc_osc_en_o}, 0);
        wake_mode_i = 1'b0;
        pulse(cmd_start_wut_i, 1);
        step(2);
        check({wut_running_o, rc_osc_en_o}, 2'b11);
        pulse(cmd_clear_i, 1);
        check(wut_running_o, 1);
        wait_hi(wake_timer_flag_o, 150);
        check(wake_timer_flag_o, 1);
        pulse(wake_timer_flag_clr_i, 1);
        check(wake_timer_flag_o, 0);
        nrt_step_i = 1'b1;
        pulse(cmd_start_nrt_i, 1);
        wait_hi(nre_flag_o, 33500);
        check(n >= 32750 && n <= 32800, 1);
    endtask
    initial begin
        step(8);
        rst_n_i = 1'b1;
        step(4);
        t_nrt();
        t_active();
        t_gpt();
        t_wut_coarse();
        test_done();
    end
endmodule
